// ===== branch_unit_consts.vh
`ifndef BRANCH_UNIT_CONSTS_VH
`define BRANCH_UNIT_CONSTS_VH

// Instruction word fields, bit 31 is the most significant bit.
`define OPC_MSB        31
`define OPC_LSB        26
`define OPC_IMM_FORM   6'h2f
`define OPC_REG_FORM   6'h27
`define DSLOT_BIT      25
`define COND_MSB       24
`define COND_LSB       21
`define CMP_SEL_MSB    20
`define CMP_SEL_LSB    16
`define OFS_SEL_MSB    15
`define OFS_SEL_LSB    11
`define ZERO_MSB       10
`define IMM_MSB        15

// Comparison selectors.
`define COND_NE        4'h1
`define COND_LT        4'h2
`define COND_LE        4'h3
`define COND_GT        4'h4

// Sequential step in bytes.
`define PC_STEP        32'h00000004

// Latencies in cycles.
`define LAT_SEQ        4'h1
`define LAT_DS         4'h2
`define LAT_NODS       4'h3
`define LAT_SMALL_DS   4'h6
`define LAT_SMALL_NODS 4'h7
`define LAT_MISS_FAST  4'h3
`define LAT_MISS_SMALL 4'h7
`define LAT_MMU_EXTRA  4'h2

// Register map, byte addresses.
`define ADR_CONFIG     4'h0
`define ADR_STATUS     4'h4
`define ADR_LAST_PC    4'h8
`define ADR_TAKEN_CNT  4'hc

// Configuration fields and reset values.
`define CFG_AREA_MSB   1
`define CFG_AREA_LSB   0
`define CFG_MMU_MSB    3
`define CFG_MMU_LSB    2
`define CFG_RESET      4'h0
`define AREA_SMALL     2'h2
`define AREA_FAST      2'h0

`endif

// ===== conditional_branch_unit.v
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "branch_unit_consts.vh"

// Overview of operation
// - Greater-than branches when signed compare exceeds zero.
// - Less-or-equal branches when compare is zero or negative.
// - Less-than branches when signed compare below zero.
// - Not-equal branches on any nonzero compare value.
// - Register form target is own address plus offset.
// - Untaken branch advances program counter by four.
// - Delay flag lets the following instruction complete.
// - Without delay flag the following instruction is squashed.
// - Sixteen-bit constant is sign-extended to thirty-two bits.
// - Preceding prefix supplies the full-width constant instead.
// - Immediate form opcode and field positions fixed.
// - Register form opcode, offset field, low eleven bits zero.
// - Untaken or correctly predicted immediate takes one cycle.
// - Fast setting, taken with delay takes two.
// - Fast setting, taken without delay takes three.
// - Small setting, taken takes six or seven.
// - Setting zero, mispredicted immediate takes three cycles.
// - Setting two, mispredicted immediate takes seven cycles.
// - Memory management above one adds two cycles to small-setting branches longer than one cycle.

module conditional_branch_unit (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Instruction issue
  input  wire        issue_i,
  input  wire [31:0] instr_i,
  input  wire [31:0] instr_addr_i,
  input  wire [31:0] compare_value_i,
  input  wire [31:0] offset_value_i,
  input  wire        prefix_valid_i,
  input  wire [15:0] prefix_high_i,
  input  wire        predict_valid_i,
  input  wire        predict_taken_i,
  output wire        ready_o,
  output wire        illegal_o,
  output wire [4:0]  compare_sel_o,
  output wire [4:0]  offset_sel_o,
  // Branch result
  output wire        done_o,
  output reg  [31:0] program_counter_o,
  output reg         taken_o,
  output reg         slot_keep_o,
  output reg         slot_squash_o,
  output wire        busy_o,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_EXEC = 2'b10;

  // Sequencer, settings and branch history.
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [3:0]  cnt;
  reg  [3:0]  next_cnt;
  reg  [3:0]  config_reg;
  reg  [31:0] last_pc;
  reg  [31:0] taken_cnt;
  reg         last_taken;
  reg         last_dslot;
  reg         last_miss;

  // Decode and datapath nets.
  wire [5:0]  opcode;
  wire [3:0]  cond;
  wire        dslot;
  wire        imm_form;
  wire        reg_form;
  wire        cond_ok;
  wire        legal;
  wire        accept;
  wire        cmp_neg;
  wire        cmp_zero;
  reg         cond_true;
  wire [31:0] imm_value;
  wire [31:0] offset;
  wire [31:0] target;
  wire [31:0] seq_pc;
  wire        miss;
  wire        fast_hit;
  wire [1:0]  area;
  wire [1:0]  mmu;
  reg  [3:0]  lat;
  wire        is_ne;
  wire        is_lt;
  wire        is_le;
  wire        is_gt;

  // Next values of the result, history and bus registers.
  reg  [31:0] next_program_counter;
  reg         next_taken;
  reg         next_slot_keep;
  reg         next_slot_squash;
  reg  [31:0] next_last_pc;
  reg         next_last_taken;
  reg         next_last_dslot;
  reg         next_last_miss;
  reg  [31:0] next_taken_cnt;
  reg  [3:0]  next_config;
  reg  [31:0] next_wb_dat;
  reg         next_wb_ack;

  // Field decode.
  assign opcode        = instr_i[`OPC_MSB:`OPC_LSB];
  assign dslot         = instr_i[`DSLOT_BIT];
  assign cond          = instr_i[`COND_MSB:`COND_LSB];
  assign imm_form      = (opcode == `OPC_IMM_FORM);
  assign reg_form      = (opcode == `OPC_REG_FORM) &&
                         (instr_i[`ZERO_MSB:0] == 11'h000);
  assign compare_sel_o = instr_i[`CMP_SEL_MSB:`CMP_SEL_LSB];
  assign offset_sel_o  = instr_i[`OFS_SEL_MSB:`OFS_SEL_LSB];

  // One decoded line per comparison keeps the legality check flat.
  assign is_ne = (cond == `COND_NE);
  assign is_lt = (cond == `COND_LT);
  assign is_le = (cond == `COND_LE);
  assign is_gt = (cond == `COND_GT);

  // Equal and greater-or-equal belong to another unit and decode as illegal here.
  assign cond_ok = is_ne || is_lt || is_le || is_gt;
  assign legal   = (imm_form || reg_form) && cond_ok;

  // Ready in the last cycle lets branches issue back to back.
  assign ready_o   = (state == S_IDLE) || (cnt == `LAT_SEQ);
  assign accept    = issue_i && ready_o;
  assign illegal_o = issue_i && ready_o && !legal;

  // Signed compare against zero.
  assign cmp_neg  = compare_value_i[31];
  assign cmp_zero = (compare_value_i == 32'h00000000);

  always @* begin
    case (cond)
      `COND_NE: cond_true = !cmp_zero;
      `COND_LT: cond_true = cmp_neg;
      `COND_LE: cond_true = cmp_neg || cmp_zero;
      `COND_GT: cond_true = !cmp_neg && !cmp_zero;
      default:  cond_true = 1'b0;
    endcase
  end

  // A prefix replaces the extended upper half with its own sixteen bits.
  assign imm_value = prefix_valid_i ?
                     {prefix_high_i, instr_i[`IMM_MSB:0]} :
                     {{16{instr_i[`IMM_MSB]}}, instr_i[`IMM_MSB:0]};
  assign offset    = imm_form ? imm_value : offset_value_i;
  assign target    = instr_addr_i + offset;
  assign seq_pc    = instr_addr_i + `PC_STEP;

  // Only the immediate form is predicted; the register form never counts as a hit.
  assign miss     = imm_form && predict_valid_i && (predict_taken_i != cond_true);
  assign fast_hit = imm_form && predict_valid_i && (predict_taken_i == cond_true);

  assign area = config_reg[`CFG_AREA_MSB:`CFG_AREA_LSB];
  assign mmu  = config_reg[`CFG_MMU_MSB:`CFG_MMU_LSB];

  // In the fast and small settings a misprediction costs the same whichever way the branch went.
  always @* begin
    lat = `LAT_SEQ;
    if (miss && (area == `AREA_FAST)) begin
      lat = `LAT_MISS_FAST;
    end else if (miss && (area == `AREA_SMALL)) begin
      lat = `LAT_MISS_SMALL;
    end else if (!cond_true || fast_hit) begin
      lat = `LAT_SEQ;
    end else if (area == `AREA_SMALL) begin
      lat = dslot ? `LAT_SMALL_DS : `LAT_SMALL_NODS;
    end else begin
      lat = dslot ? `LAT_DS : `LAT_NODS;
    end
    if ((mmu > 2'h1) && (area == `AREA_SMALL) && (lat != `LAT_SEQ)) begin
      lat = lat + `LAT_MMU_EXTRA;
    end
  end

  // Sequencer: done waits until the counted latency runs out.
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      S_IDLE: begin
        if (accept && legal) begin
          next_state = S_EXEC;
          next_cnt   = lat;
        end
      end
      S_EXEC: begin
        if (cnt == `LAT_SEQ) begin
          if (accept && legal) begin
            next_cnt = lat;
          end else begin
            next_state = S_IDLE;
            next_cnt   = 4'h0;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_cnt   = 4'h0;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cnt   <= 4'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Done and busy are decoded from one counter, so they never disagree.
  assign done_o = (state == S_EXEC) && (cnt == `LAT_SEQ);
  assign busy_o = (state == S_EXEC) && (cnt != `LAT_SEQ);

  // Result registers; no general register or status bit is ever written.
  // Outputs hold until the next accepted branch replaces them.
  always @* begin
    next_program_counter = program_counter_o;
    next_taken           = taken_o;
    next_slot_keep       = slot_keep_o;
    next_slot_squash     = slot_squash_o;
    if (accept && legal) begin
      next_program_counter = cond_true ? target : seq_pc;
      next_taken           = cond_true;
      next_slot_keep       = cond_true && dslot;
      next_slot_squash     = cond_true && !dslot;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      program_counter_o <= 32'h00000000;
      taken_o           <= 1'b0;
      slot_keep_o       <= 1'b0;
      slot_squash_o     <= 1'b0;
    end else begin
      program_counter_o <= next_program_counter;
      taken_o           <= next_taken;
      slot_keep_o       <= next_slot_keep;
      slot_squash_o     <= next_slot_squash;
    end
  end

  // Software visible history of the last branch.
  always @* begin
    next_last_pc    = last_pc;
    next_last_taken = last_taken;
    next_last_dslot = last_dslot;
    next_last_miss  = last_miss;
    if (accept && legal) begin
      next_last_pc    = instr_addr_i;
      next_last_taken = cond_true;
      next_last_dslot = dslot;
      next_last_miss  = miss;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      last_pc    <= 32'h00000000;
      last_taken <= 1'b0;
      last_dslot <= 1'b0;
      last_miss  <= 1'b0;
    end else begin
      last_pc    <= next_last_pc;
      last_taken <= next_last_taken;
      last_dslot <= next_last_dslot;
      last_miss  <= next_last_miss;
    end
  end

  // Bus access, single-cycle acknowledge for every address including unmapped ones.
  // The acknowledge masks the request, so a held strobe is served again on every other cycle.
  wire        wb_req;
  wire        wb_wr;
  wire        wb_rd;
  wire        cfg_wr;
  wire        cnt_clear;
  wire [31:0] status_word;
  assign wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr     = wb_req && wb_we_i;
  assign wb_rd     = wb_req && !wb_we_i;
  assign cfg_wr    = wb_wr && (wb_adr_i == `ADR_CONFIG) && wb_sel_i[0];
  assign cnt_clear = wb_wr && (wb_adr_i == `ADR_TAKEN_CNT);

  always @* begin
    next_wb_ack = wb_req;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= next_wb_ack;
    end
  end

  // The settings are sampled at issue, so a change mid-branch waits for the next one.
  always @* begin
    next_config = config_reg;
    if (cfg_wr) begin
      next_config = wb_dat_i[3:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= `CFG_RESET;
    end else begin
      config_reg <= next_config;
    end
  end

  // A counter write of any value clears it; an increment in the same cycle leaves it at one.
  always @* begin
    next_taken_cnt = taken_cnt;
    if (accept && legal && cond_true) begin
      next_taken_cnt = cnt_clear ? 32'h00000001 : taken_cnt + 32'h00000001;
    end else if (cnt_clear) begin
      next_taken_cnt = 32'h00000000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      taken_cnt <= 32'h00000000;
    end else begin
      taken_cnt <= next_taken_cnt;
    end
  end

  // Status shows the live sequencer state beside the history of the last branch.
  assign status_word = {27'h0, last_miss, last_dslot, last_taken, busy_o, done_o};

  always @* begin
    next_wb_dat = wb_dat_o;
    if (wb_rd) begin
      case (wb_adr_i)
        `ADR_CONFIG:    next_wb_dat = {28'h0000000, config_reg};
        `ADR_STATUS:    next_wb_dat = status_word;
        `ADR_LAST_PC:   next_wb_dat = last_pc;
        `ADR_TAKEN_CNT: next_wb_dat = taken_cnt;
        default:        next_wb_dat = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= next_wb_dat;
    end
  end

endmodule // conditional_branch_unit

// ===== cbu_monitor.sv
`timescale 1ns/1ns
module cbu_monitor (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Issue side
  input wire        issue_i,
  input wire [31:0] instr_i,
  input wire [31:0] instr_addr_i,
  input wire [31:0] compare_value_i,
  input wire [31:0] offset_value_i,
  input wire        ready_o,
  input wire        illegal_o,
  input wire [4:0]  compare_sel_o,
  input wire [4:0]  offset_sel_o,
  // Result side
  input wire        done_o,
  input wire [31:0] program_counter_o,
  input wire        taken_o,
  input wire        slot_keep_o,
  input wire        slot_squash_o,
  input wire        busy_o,
  // Bus
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o
);
  wire rf;
  assign rf = issue_i & ready_o & ~illegal_o & (instr_i[31:26] == 6'h27);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_sel;
    compare_sel_o == instr_i[20:16] && offset_sel_o == instr_i[15:11];
  endproperty
  a_sel: assert property (p_sel) else $error("register selects wrong");
  property p_ill;
    issue_i && ready_o && instr_i[31:26] == 6'h27 && instr_i[10:0] != 11'h0 |-> illegal_o;
  endproperty
  a_ill: assert property (p_ill) else $error("bad register form accepted");
  property p_rdy;
    ready_o == !busy_o && !(done_o && busy_o);
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready and busy disagree");
  property p_gt;
    rf && instr_i[24:21] == 4'h4 |=> taken_o == ($signed($past(compare_value_i)) > 0);
  endproperty
  a_gt: assert property (p_gt) else $error("greater-than decision wrong");
  property p_nt;
    rf && !compare_value_i[31] && compare_value_i != 0 && instr_i[24:21] == 4'h3
      |=> done_o && program_counter_o == $past(instr_addr_i) + 32'h4;
  endproperty
  a_nt: assert property (p_nt) else $error("untaken branch wrong");
  property p_tk;
    rf && instr_i[24:21] == 4'h1 && compare_value_i != 0
      |=> program_counter_o == $past(instr_addr_i) + $past(offset_value_i);
  endproperty
  a_tk: assert property (p_tk) else $error("register target wrong");
  property p_ds;
    rf && instr_i[24:21] == 4'h2 && compare_value_i[31] |=> slot_keep_o == $past(instr_i[25]);
  endproperty
  a_ds: assert property (p_ds) else $error("delay slot flag lost");
  property p_slot;
    (slot_keep_o || slot_squash_o) == taken_o && !(slot_keep_o && slot_squash_o);
  endproperty
  a_slot: assert property (p_slot) else $error("slot outputs inconsistent");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus acknowledge wrong");
endmodule // cbu_monitor
bind conditional_branch_unit cbu_monitor cbu_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .issue_i(issue_i), .instr_i(instr_i), .instr_addr_i(instr_addr_i),
  .compare_value_i(compare_value_i), .offset_value_i(offset_value_i), .ready_o(ready_o),
  .illegal_o(illegal_o), .compare_sel_o(compare_sel_o), .offset_sel_o(offset_sel_o),
  .done_o(done_o), .program_counter_o(program_counter_o), .taken_o(taken_o),
  .slot_keep_o(slot_keep_o), .slot_squash_o(slot_squash_o), .busy_o(busy_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// ===== tb.sv
`timescale 1ns/1ns
module tb;
  reg clk_i = 0, rst_i = 1, issue_i = 0, prefix_valid_i = 0, predict_valid_i = 0;
  reg predict_taken_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [31:0] instr_i = 0, instr_addr_i = 0, compare_value_i = 0, offset_value_i = 0;
  reg [31:0] wb_dat_i = 0, a, b, v, cv, la;
  reg [15:0] prefix_high_i = 0, lf = 16'hade4;
  reg [3:0]  wb_adr_i = 0, wb_sel_i = 4'hf;
  reg [1:0]  area, mmu;
  wire       ready_o, illegal_o, done_o, taken_o, slot_keep_o, slot_squash_o, busy_o, wb_ack_o;
  wire [4:0] compare_sel_o, offset_sel_o;
  wire [31:0] program_counter_o, wb_dat_o;
  reg [38:0] bq[$];
  reg [31:0] rq[$];
  reg        iq[$];
  reg [2:0]  lst = 0;
  integer num_errors = 0, check_count = 0, cnt = 0, cycles = 0, ntk, j, k;
  conditional_branch_unit conditional_branch_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
    .issue_i(issue_i), .instr_i(instr_i), .instr_addr_i(instr_addr_i),
    .compare_value_i(compare_value_i), .offset_value_i(offset_value_i),
    .prefix_valid_i(prefix_valid_i), .prefix_high_i(prefix_high_i),
    .predict_valid_i(predict_valid_i), .predict_taken_i(predict_taken_i), .ready_o(ready_o),
    .illegal_o(illegal_o), .compare_sel_o(compare_sel_o), .offset_sel_o(offset_sel_o),
    .done_o(done_o), .program_counter_o(program_counter_o), .taken_o(taken_o),
    .slot_keep_o(slot_keep_o), .slot_squash_o(slot_squash_o), .busy_o(busy_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  always #10 clk_i = ~clk_i;
  task wrap_up;
    begin
      $display("Checks %0d, errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task cmp_br(input [38:0] got, input [38:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmp_rd(input [31:0] got, input [31:0] exp);
    begin
      cmp_br({7'h0, got}, {7'h0, exp});
    end
  endtask
  task cmp_flag(input got, input exp);
    begin
      cmp_rd({31'h0, got}, {31'h0, exp});
    end
  endtask
  task rnd32(output [31:0] r);
    begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      r[31:16] = lf;
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      r[15:0] = lf;
    end
  endtask
  // A read passes its expected value in d; the slave ignores write data on reads.
  task wb(input we, input [3:0] adr, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      if (!we)
        rq.push_back(d);
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
        @(posedge clk_i);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_i);
    end
  endtask
  task br(input im, input d, input [3:0] c, input [31:0] ad, input pv, input prv, input prt);
    reg tk;
    reg miss;
    reg [31:0] tg;
    reg [3:0] l;
    begin
      tk = c == 1 ? cv != 0 : c == 2 ? cv[31] : c == 3 ? cv[31] || cv == 0 : !cv[31] && cv != 0;
      tg = ad + (!im ? a : pv ? b : {{16{b[15]}}, b[15:0]});
      miss = im && prv && prt != tk;
      l = miss && area == 0 ? 3 : miss && area == 2 ? 7 : !tk || (im && prv && !miss) ? 1 :
          area == 2 ? (d ? 6 : 7) : (d ? 2 : 3);
      if (mmu > 1 && area == 2 && l != 1)
        l = l + 2;
      @(posedge clk_i);
      issue_i <= 1;
      instr_i <= {im ? 6'h2f : 6'h27, d, c, 5'h3, im ? b[15:0] : 16'h2000};
      instr_addr_i <= ad;
      compare_value_i <= cv;
      offset_value_i <= a;
      prefix_valid_i <= pv && im;
      prefix_high_i <= b[31:16];
      predict_valid_i <= prv;
      predict_taken_i <= prt;
      iq.push_back(1'b0);
      @(posedge clk_i);
      while (ready_o !== 1'b1)
        @(posedge clk_i);
      bq.push_back({l, tk, tk && d, tk && !d, tk ? tg : ad + 32'h4});
      lst = {miss, d, tk};
      ntk = ntk + tk;
      issue_i <= 0;
    end
  endtask
  always @(negedge clk_i) begin
    cnt = cnt + 1;
    if (done_o === 1'b1)
      cmp_br({cnt[3:0], taken_o, slot_keep_o, slot_squash_o, program_counter_o},
             bq.pop_front());
    if (wb_ack_o === 1'b1 && !wb_we_i)
      cmp_rd(wb_dat_o, rq.pop_front());
    if (issue_i === 1'b1 && ready_o === 1'b1)
      cmp_flag(illegal_o, iq.pop_front());
    if (issue_i && ready_o === 1'b1 && illegal_o === 1'b0)
      cnt = 0;
  end
  // The whole run needs under 3000 cycles, so this ceiling only trips on a hang.
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 0;
    for (k = 0; k < 6; k = k + 1) begin
      area = k % 3;
      mmu = k < 3 ? 2'h0 : 2'h2;
      wb(1, 4'h0, {28'h0, mmu, area});
      wb(0, 4'h0, {28'h0, mmu, area});
      wb(1, 4'hc, 32'h1);
      ntk = 0;
      for (j = 0; j < 24; j = j + 1) begin
        rnd32(a);
        rnd32(b);
        rnd32(v);
        cv = j % 4 == 0 ? 0 : j % 4 == 1 ? 1 : j % 4 == 2 ? 32'hffffffff : v;
        la = {v[31:2], 2'h0};
        br(v[5], v[6], (j / 4) % 4 + 1, la, v[7], v[8], v[9]);
      end
      wb(0, 4'hc, ntk);
      wb(0, 4'h8, la);
      wb(0, 4'h2, 32'h0);
      wb(0, 4'h4, {27'h0, lst, 2'h0});
    end
    // A register form with stray low bits must be refused without a result.
    @(posedge clk_i);
    issue_i <= 1;
    instr_i <= {6'h27, 1'b0, 4'h1, 5'h1, 5'h2, 11'h1};
    iq.push_back(1'b1);
    @(posedge clk_i);
    issue_i <= 0;
    wb(0, 4'hc, ntk);
    repeat (10) @(posedge clk_i);
    wrap_up;
  end
endmodule // tb
